// *** cpu_model.sv ***
// cpu stand-in: takes the offered vector, promptly or after a chosen delay
// assumes the controller's clock; ack is a one-cycle pulse
`timescale 1ns/100ps
module cpu_model (
  input  wire logic       core_clk_in, // system clock
  input  wire logic       en_in,       // accept requests
  input  wire logic [3:0] delay_in,    // extra wait after an ack
  input  wire logic       req_in,      // request from controller
  output logic            ack_out      // exception handling taken
);
  logic [4:0] wait_reg = 5'h00;
  initial ack_out = 1'b0;
  // three edges minimum so the cleared flag reaches the outputs before a new ack
  always @(posedge core_clk_in) begin
    ack_out <= 1'b0;
    if (wait_reg != 5'h00) begin
      wait_reg <= wait_reg - 5'h01;
    end else if (en_in && req_in === 1'b1) begin
      ack_out  <= 1'b1;
      wait_reg <= {1'b0, delay_in} + 5'h03;
    end
  end
endmodule : cpu_model

// *** intc_asserts.sv ***
// port-level checks for the interrupt source and priority/vector block
// assumes one clock domain; bound to every instance of the design top below
`timescale 1ns/100ps
module intc_asserts
  import intc_pkg::*;
#(
  parameter int NUM_IRQ = intc_pkg::IRQ_COUNT
) (
  input wire logic                 core_clk_in,  // system clock
  input wire logic                 rst_in,       // async reset, active high
  input wire logic                 psel_in,      // apb select
  input wire logic                 penable_in,   // apb access phase
  input wire logic                 pready_out,   // apb ready
  input wire logic                 pslverr_out,  // apb error
  input wire logic [INT_COUNT-1:0] int_req_in,   // peripheral requests
  input wire logic                 mask_i_in,    // interrupt mask
  input wire logic                 mask_ui_in,   // user mask
  input wire logic                 int_req_out,  // request to cpu
  input intc_pkg::vec_t            vec_num_out,  // vector number
  input wire logic [VADDR_W-1:0]   vec_addr_out, // vector address
  input wire logic [INT_COUNT-1:0] dma_trig_out  // dma routed requests
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  a_vec_addr_times4: assert property (
    int_req_out |-> vec_addr_out == {8'h00, vec_num_out, 2'b00})
    else $error("vector address is not four times the vector");
  a_idle_vec_zero: assert property (
    !int_req_out |-> vec_num_out == 6'h00 && vec_addr_out == 16'h0000)
    else $error("vector outputs not zero while idle");
  a_nmi_only_masked: assert property (
    $past(mask_i_in) && $past(mask_ui_in) && int_req_out |-> vec_num_out == VEC_NMI)
    else $error("a maskable source passed with both masks set");
  a_vec_legal_set: assert property (
    int_req_out |-> vec_num_out inside {7, [12:21], [24:26], [28:30], [32:34], [36:38],
                                        [40:42], [44:60]})
    else $error("vector outside the source table");
  a_dma_needs_req: assert property ((dma_trig_out & ~$past(int_req_in)) == '0)
    else $error("dma trigger without a peripheral request");
  a_dma_capable_only: assert property ((dma_trig_out & ~DMA_CAPABLE) == '0)
    else $error("dma trigger from a source that cannot route to dma");
  a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("ready missing in the first access cycle");
  a_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("ready held beyond one cycle");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error flag without ready");

  cover property (int_req_out && vec_num_out == VEC_NMI);
  cover property (pslverr_out);
  cover property (|dma_trig_out);
endmodule : intc_asserts

bind interrupt_source_priority_vector intc_asserts #(.NUM_IRQ(NUM_IRQ)) i_intc_asserts (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .int_req_in(int_req_in),
  .mask_i_in(mask_i_in), .mask_ui_in(mask_ui_in), .int_req_out(int_req_out),
  .vec_num_out(vec_num_out), .vec_addr_out(vec_addr_out), .dma_trig_out(dma_trig_out));

// *** intc_pkg.sv ***
// constants for the interrupt source front end and priority/vector selection
// assumes an apb slave at 32-bit data, one word per register
package intc_pkg;

  localparam int IRQ_COUNT  = 8;
  localparam int INT_COUNT  = 34;
  localparam int SRC_COUNT  = 1 + IRQ_COUNT + INT_COUNT;
  localparam int SRC_W      = 6;
  localparam int VEC_W      = 6;
  localparam int VADDR_W    = 16;
  localparam int PRIO_NONE  = 16;

  typedef logic [SRC_W-1:0] src_idx_t;
  typedef logic [VEC_W-1:0] vec_t;

  // apb register byte offsets
  localparam logic [7:0] OFF_SYS_CTRL    = 8'h00;
  localparam logic [7:0] OFF_SENSE_CTRL  = 8'h04;
  localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h0C;
  localparam logic [7:0] OFF_PRIO_A      = 8'h10;
  localparam logic [7:0] OFF_PRIO_B      = 8'h14;
  localparam logic [7:0] OFF_INT_EN_LO   = 8'h18;
  localparam logic [7:0] OFF_INT_EN_HI   = 8'h1C;
  localparam logic [7:0] OFF_INT_FLAG_LO = 8'h20;
  localparam logic [7:0] OFF_INT_FLAG_HI = 8'h24;
  localparam logic [7:0] OFF_DMA_SEL_LO  = 8'h28;
  localparam logic [7:0] OFF_DMA_SEL_HI  = 8'h2C;
  localparam logic [7:0] OFF_CUR_STATE   = 8'h30;

  // system_ctrl_reg fields
  localparam int SYS_NMI_EDGE_BIT = 2;
  localparam int SYS_UE_BIT       = 3;
  localparam logic [7:0] SYS_CTRL_RESET = 8'h08;
  localparam logic [7:0] SYS_CTRL_MASK  = 8'h0C;
  localparam logic [7:0] BYTE_RESET     = 8'h00;

  // cur_state fields
  localparam int CUR_NMI_BIT = 0;
  localparam int CUR_REQ_BIT = 1;
  localparam int CUR_VEC_LSB = 8;

  // only timer-unit and serial-channel sources may be routed to the dma controller
  localparam logic [INT_COUNT-1:0] DMA_CAPABLE = 34'h1FE01FFFC;

  localparam vec_t VEC_NMI  = 6'h07;
  localparam vec_t VEC_IRQ0 = 6'h0C;

  // vector of each source: 0 nmi, 1..8 irq0..7, 9..42 internal in table order
  localparam vec_t SRC_VEC [SRC_COUNT] = '{
    6'h07, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13,
    6'h14, 6'h15,
    6'h18, 6'h19, 6'h1A, 6'h1C, 6'h1D, 6'h1E, 6'h20, 6'h21, 6'h22,
    6'h24, 6'h25, 6'h26, 6'h28, 6'h29, 6'h2A,
    6'h2C, 6'h2D, 6'h2E, 6'h2F, 6'h30, 6'h31, 6'h32, 6'h33,
    6'h34, 6'h35, 6'h36, 6'h37, 6'h38, 6'h39, 6'h3A, 6'h3B,
    6'h3C};

  // index into {priority_reg_a, priority_reg_b}: 15 = a7 ... 8 = a0, 7 = b7 ... 0 = b0
  localparam logic [4:0] SRC_PRIO [SRC_COUNT] = '{
    5'h10, 5'h0F, 5'h0E, 5'h0D, 5'h0D, 5'h0C, 5'h0C, 5'h0C, 5'h0C,
    5'h0B, 5'h10,
    5'h0A, 5'h0A, 5'h0A, 5'h09, 5'h09, 5'h09, 5'h08, 5'h08, 5'h08,
    5'h07, 5'h07, 5'h07, 5'h06, 5'h06, 5'h06,
    5'h05, 5'h05, 5'h05, 5'h05, 5'h04, 5'h04, 5'h04, 5'h04,
    5'h03, 5'h03, 5'h03, 5'h03, 5'h02, 5'h02, 5'h02, 5'h02,
    5'h01};

endpackage : intc_pkg

// *** interrupt_source_priority_vector.sv ***
// interrupt source front end with priority arbitration and vector generation
// assumes an apb master on core_clk_in; internal requests come from on-chip logic
// on the same clock; nmi and irq pins are asynchronous
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/100ps

// Overview of operation
// - nine external plus thirty-four internal sources
// - only nmi and irq0-2 wake from standby
// - nmi highest, accepted regardless of mask bits
// - nmi_edge_select picks rising or falling nmi edge
// - nmi uses vector 7 at 001C
// - irq_sense_bit selects low level or falling edge
// - irq_enable bit gates each irq request
// - priority_reg_a bits 7..4 set irq levels
// - irq_status flags show requests, software clears them
// - irq0..7 use vectors 12 through 19
// - irq detected whatever the pin direction
// - internal sources have status flags and enables
// - dma-routed timer/serial requests bypass interrupt controller
// - equal level, smaller vector number wins
// - priority adjustable, default vector order after reset
// - vector address is vector number times four
// - timer channels 0-4 vectors 24..42, own bits
// - serial channels at 52-55 and 56-59
// - irq flag set on low level or fall
// - flag cleared by read-then-write-zero or handling
// - priority bit clear is level 0, set level 1
module interrupt_source_priority_vector
  import intc_pkg::*;
#(
  parameter int NUM_IRQ = intc_pkg::IRQ_COUNT
) (
  input  wire logic                           core_clk_in,   // system clock, 50 MHz
  input  wire logic                           rst_in,        // async reset, active high
  input  wire logic                           psel_in,       // apb select
  input  wire logic                           penable_in,    // apb access phase
  input  wire logic                           pwrite_in,     // apb direction
  input  wire logic [7:0]                     paddr_in,      // apb byte address
  input  wire logic [31:0]                    pwdata_in,     // apb write data
  output logic      [31:0]                    prdata_out,    // apb read data
  output logic                                pready_out,    // apb ready
  output logic                                pslverr_out,   // apb error, unmapped
  input  wire logic                           nmi_pin_in,    // nmi pin, async
  input  wire logic [NUM_IRQ-1:0]             irq_pin_n_in,  // irq pins, active low
  input  wire logic [intc_pkg::INT_COUNT-1:0] int_req_in,    // peripheral request levels
  input  wire logic                           mask_i_in,     // interrupt_mask_bit of cond_code_reg
  input  wire logic                           mask_ui_in,    // user_mask_bit of cond_code_reg
  input  wire logic                           cpu_ack_in,    // exception handling taken
  output logic                                int_req_out,   // accepted request to cpu
  output intc_pkg::vec_t                      vec_num_out,   // vector number
  output logic      [intc_pkg::VADDR_W-1:0]   vec_addr_out,  // vector address, low 16 bits
  output logic                                wake_out,      // standby wake request
  output logic      [intc_pkg::INT_COUNT-1:0] dma_trig_out   // requests routed to dma
);

  import intc_pkg::*;

  initial begin
    if (NUM_IRQ != IRQ_COUNT) $error("NUM_IRQ must match the vector table");
  end

  // registers
  logic [7:0]           sys_ctrl_reg;
  logic [7:0]           irq_sense_ctrl_reg;
  logic [7:0]           irq_enable_reg;
  logic [7:0]           priority_reg_a_reg;
  logic [7:0]           priority_reg_b_reg;
  logic [INT_COUNT-1:0] int_enable_reg;
  logic [INT_COUNT-1:0] dma_route_reg;
  logic [NUM_IRQ-1:0]   status_read_reg;

  // apb state
  logic                 pready_reg;
  logic [31:0]          prdata_reg;
  logic                 pslverr_reg;
  logic                 wr_fire;
  logic                 rd_fire;
  logic                 setup_phase;
  logic [31:0]          rd_mux;
  logic                 addr_hit;

  // sources
  logic [2:0]           nmi_sync_reg;
  logic                 nmi_edge;
  logic                 nmi_pending_reg;
  logic [NUM_IRQ-1:0]   irq_flag;
  logic [NUM_IRQ-1:0]   irq_sw_clear;
  logic [NUM_IRQ-1:0]   irq_hw_ack;
  logic [INT_COUNT-1:0] int_to_dma;
  logic [INT_COUNT-1:0] int_to_intc;

  // arbitration
  logic [SRC_COUNT-1:0] src_req;
  logic [SRC_COUNT-1:0] src_lvl;
  logic [SRC_COUNT-1:0] src_ok;
  logic [16:0]          prio_vec;
  src_idx_t             sel_hi;
  src_idx_t             sel_any;
  logic                 hit_hi;
  logic                 hit_any;
  vec_t                 win_vec;
  logic                 win_valid;

  logic                 int_req_reg;
  vec_t                 vec_num_reg;
  logic                 wake_reg;
  logic [INT_COUNT-1:0] dma_trig_reg;

  // ---------------------------------------------------------------- apb slave
  assign setup_phase = psel_in & ~penable_in;
  assign wr_fire     = psel_in & penable_in & pready_reg & pwrite_in;
  assign rd_fire     = psel_in & penable_in & pready_reg & ~pwrite_in;

  always_comb begin
    rd_mux   = '0;
    addr_hit = 1'b1;
    unique case (paddr_in)
      OFF_SYS_CTRL:    rd_mux[7:0] = sys_ctrl_reg;
      OFF_SENSE_CTRL:  rd_mux[7:0] = irq_sense_ctrl_reg;
      OFF_IRQ_ENABLE:  rd_mux[7:0] = irq_enable_reg;
      OFF_IRQ_STATUS:  rd_mux[NUM_IRQ-1:0] = irq_flag;
      OFF_PRIO_A:      rd_mux[7:0] = priority_reg_a_reg;
      OFF_PRIO_B:      rd_mux[7:0] = priority_reg_b_reg;
      OFF_INT_EN_LO:   rd_mux = int_enable_reg[31:0];
      OFF_INT_EN_HI:   rd_mux[INT_COUNT-33:0] = int_enable_reg[INT_COUNT-1:32];
      OFF_INT_FLAG_LO: rd_mux = int_req_in[31:0];
      OFF_INT_FLAG_HI: rd_mux[INT_COUNT-33:0] = int_req_in[INT_COUNT-1:32];
      OFF_DMA_SEL_LO:  rd_mux = dma_route_reg[31:0];
      OFF_DMA_SEL_HI:  rd_mux[INT_COUNT-33:0] = dma_route_reg[INT_COUNT-1:32];
      OFF_CUR_STATE: begin
        rd_mux[CUR_NMI_BIT]                   = nmi_pending_reg;
        rd_mux[CUR_REQ_BIT]                   = int_req_reg;
        rd_mux[CUR_VEC_LSB +: VEC_W]          = vec_num_reg;
      end
      default:         addr_hit = 1'b0;
    endcase
  end

  // read data is captured in the setup cycle so the access phase needs no wait state
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup_phase;
      if (setup_phase) begin
        prdata_reg  <= pwrite_in ? '0 : rd_mux;
        pslverr_reg <= ~addr_hit;
      end else if (pready_reg) begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign pready_out  = pready_reg;
  assign prdata_out  = prdata_reg;
  assign pslverr_out = pslverr_reg;

  // ---------------------------------------------------------------- control registers
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sys_ctrl_reg       <= SYS_CTRL_RESET;
      irq_sense_ctrl_reg <= BYTE_RESET;
      irq_enable_reg     <= BYTE_RESET;
      priority_reg_a_reg <= BYTE_RESET;
      priority_reg_b_reg <= BYTE_RESET;
    end else if (wr_fire) begin
      unique case (paddr_in)
        OFF_SYS_CTRL:   sys_ctrl_reg       <= pwdata_in[7:0] & SYS_CTRL_MASK;
        OFF_SENSE_CTRL: irq_sense_ctrl_reg <= pwdata_in[7:0];
        OFF_IRQ_ENABLE: irq_enable_reg     <= pwdata_in[7:0];
        OFF_PRIO_A:     priority_reg_a_reg <= pwdata_in[7:0];
        OFF_PRIO_B:     priority_reg_b_reg <= pwdata_in[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      int_enable_reg <= '0;
      dma_route_reg  <= '0;
    end else if (wr_fire) begin
      unique case (paddr_in)
        OFF_INT_EN_LO:  int_enable_reg[31:0] <= pwdata_in;
        OFF_INT_EN_HI:  int_enable_reg[INT_COUNT-1:32] <= pwdata_in[INT_COUNT-33:0];
        OFF_DMA_SEL_LO: dma_route_reg[31:0] <= pwdata_in & DMA_CAPABLE[31:0];
        OFF_DMA_SEL_HI: dma_route_reg[INT_COUNT-1:32] <=
                          pwdata_in[INT_COUNT-33:0] & DMA_CAPABLE[INT_COUNT-1:32];
        default: ;
      endcase
    end
  end

  // a flag may only be cleared by a zero after it has been read as one
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_read_reg <= '0;
    end else if (rd_fire && paddr_in == OFF_IRQ_STATUS) begin
      status_read_reg <= irq_flag;
    end else if (wr_fire && paddr_in == OFF_IRQ_STATUS) begin
      status_read_reg <= '0;
    end
  end

  assign irq_sw_clear = (wr_fire && paddr_in == OFF_IRQ_STATUS) ?
                        (status_read_reg & ~pwdata_in[NUM_IRQ-1:0]) : '0;

  // ---------------------------------------------------------------- nmi
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      // idle-high reset level: a switch to rising mode right after reset sees no false edge
      nmi_sync_reg <= '1;
    end else begin
      nmi_sync_reg <= {nmi_sync_reg[1:0], nmi_pin_in};
    end
  end

  // stage 0 feeds only stage 1; the edge compares the two later stages
  assign nmi_edge = sys_ctrl_reg[SYS_NMI_EDGE_BIT] ?
                    (nmi_sync_reg[1] & ~nmi_sync_reg[2]) :
                    (~nmi_sync_reg[1] & nmi_sync_reg[2]);

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      nmi_pending_reg <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pending_reg <= 1'b1;
    end else if (cpu_ack_in && int_req_reg && vec_num_reg == VEC_NMI) begin
      nmi_pending_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------- irq pins
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
      assign irq_hw_ack[gi] = cpu_ack_in & int_req_reg &
                              (vec_num_reg == VEC_IRQ0 + vec_t'(gi));
      irq_pin_channel #(
        .SYNC_STAGES (2)
      ) u_chan (
        .core_clk_in   (core_clk_in),
        .rst_in        (rst_in),
        .pin_n_in      (irq_pin_n_in[gi]),
        .sense_edge_in (irq_sense_ctrl_reg[gi]),
        .sw_clear_in   (irq_sw_clear[gi]),
        .hw_ack_in     (irq_hw_ack[gi]),
        .flag_out      (irq_flag[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------- internal sources
  assign int_to_dma  = int_req_in & int_enable_reg & dma_route_reg;
  assign int_to_intc = int_req_in & int_enable_reg & ~dma_route_reg;

  // ---------------------------------------------------------------- arbitration
  assign prio_vec = {1'b0, priority_reg_a_reg, priority_reg_b_reg};

  assign src_req = {int_to_intc, irq_flag & irq_enable_reg, nmi_pending_reg};

  always_comb begin
    for (int s = 0; s < SRC_COUNT; s++) begin
      src_lvl[s] = prio_vec[SRC_PRIO[s]];
    end
    src_lvl[0] = 1'b1;
  end

  // masking per cond_code_reg; nmi passes whatever the mask bits say
  always_comb begin
    for (int s = 0; s < SRC_COUNT; s++) begin
      src_ok[s] = src_req[s] &
                  (~mask_i_in | (~sys_ctrl_reg[SYS_UE_BIT] & ~mask_ui_in & src_lvl[s]));
    end
    src_ok[0] = src_req[0];
  end

  // sources sit in vector order, so scanning downward leaves the smallest vector
  always_comb begin
    sel_hi  = '0;
    sel_any = '0;
    hit_hi  = 1'b0;
    hit_any = 1'b0;
    for (int s = SRC_COUNT - 1; s >= 0; s--) begin
      if (src_ok[s] && src_lvl[s]) begin
        sel_hi = src_idx_t'(s);
        hit_hi = 1'b1;
      end
      if (src_ok[s]) begin
        sel_any = src_idx_t'(s);
        hit_any = 1'b1;
      end
    end
  end

  assign win_valid = hit_any;
  assign win_vec   = hit_hi ? SRC_VEC[sel_hi] : SRC_VEC[sel_any];

  // ---------------------------------------------------------------- outputs
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      int_req_reg <= 1'b0;
      vec_num_reg <= '0;
    end else begin
      int_req_reg <= win_valid;
      vec_num_reg <= win_valid ? win_vec : '0;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      vec_addr_out <= '0;
    end else begin
      vec_addr_out <= win_valid ? {8'h00, win_vec, 2'b00} : '0;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= nmi_pending_reg | (|(irq_flag[2:0] & irq_enable_reg[2:0]));
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dma_trig_reg <= '0;
    end else begin
      dma_trig_reg <= int_to_dma;
    end
  end

  assign int_req_out  = int_req_reg;
  assign vec_num_out  = vec_num_reg;
  assign wake_out     = wake_reg;
  assign dma_trig_out = dma_trig_reg;

endmodule : interrupt_source_priority_vector

// *** irq_pin_channel.sv ***
// one external irq pin: synchroniser, falling-edge / low-level sense, status flag
// assumes the pin is asynchronous to core_clk_in and active low
`timescale 1ns/100ps
module irq_pin_channel #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic core_clk_in,    // system clock
  input  wire logic rst_in,         // async reset, active high
  input  wire logic pin_n_in,       // raw active-low irq pin
  input  wire logic sense_edge_in,  // 1 falling edge, 0 low level
  input  wire logic sw_clear_in,    // software clear pulse
  input  wire logic hw_ack_in,      // exception handling taken for this irq
  output logic      flag_out        // irq_status_flag
);

  initial begin
    if (SYNC_STAGES < 2) $error("irq_pin_channel needs at least two sync stages");
  end

  logic [SYNC_STAGES-1:0] sync_reg;
  logic                   last_reg;
  logic                   pin_high;
  logic                   fall_seen;
  logic                   set_cond;
  logic                   clr_cond;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_reg <= '1;
      last_reg <= 1'b1;
    end else begin
      sync_reg <= {sync_reg[SYNC_STAGES-2:0], pin_n_in};
      last_reg <= sync_reg[SYNC_STAGES-1];
    end
  end

  // pin is sampled straight, so port direction has no effect on detection
  assign pin_high  = sync_reg[SYNC_STAGES-1];
  assign fall_seen = last_reg & ~pin_high;
  assign set_cond  = sense_edge_in ? fall_seen : ~pin_high;
  assign clr_cond  = sw_clear_in | (hw_ack_in & (sense_edge_in | pin_high));

  // a new event beats a clear in the same cycle
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_out <= 1'b0;
    end else if (set_cond) begin
      flag_out <= 1'b1;
    end else if (clr_cond) begin
      flag_out <= 1'b0;
    end
  end

endmodule : irq_pin_channel

// *** tb_top.sv ***
// self-checking bench for the interrupt source and priority/vector block
// assumes a cpu_model partner and the checker bound in its own file
`timescale 1ns/100ps
module tb_top;
  import intc_pkg::*;
  logic                 core_clk_in = 1'b0;
  logic                 rst_in = 1'b1;
  logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]           paddr = 8'h00, irq_n = 8'hFF;
  logic [31:0]          pwdata = 32'h0, prdata, seed = 32'h8FA4F75A;
  logic                 pready, pslverr, ack, int_req_o, wake;
  logic                 nmi_pin = 1'b1, mask_i = 1'b0, mask_ui = 1'b0, cpu_en = 1'b0;
  logic [INT_COUNT-1:0] int_req = '0, dma_trig;
  logic [15:0]          vaddr;
  logic [3:0]           delay = 4'h0;
  vec_t                 vec, e;
  logic [32:0]          rdq[$];
  vec_t                 vq[$];
  int                   n_errors = 0, checks = 0;

  always #10 core_clk_in = ~core_clk_in;

  interrupt_source_priority_vector i_interrupt_source_priority_vector (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .nmi_pin_in(nmi_pin), .irq_pin_n_in(irq_n),
    .int_req_in(int_req), .mask_i_in(mask_i), .mask_ui_in(mask_ui), .cpu_ack_in(ack),
    .int_req_out(int_req_o), .vec_num_out(vec), .vec_addr_out(vaddr), .wake_out(wake),
    .dma_trig_out(dma_trig));
  cpu_model i_cpu_model (.core_clk_in(core_clk_in), .en_in(cpu_en), .delay_in(delay),
    .req_in(int_req_o), .ack_out(ack));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // priority bit covering irq i within the upper nibble of priority_reg_a
  function automatic logic lvl(input logic [3:0] nb, input int i);
    return i == 0 ? nb[3] : i == 1 ? nb[2] : i < 4 ? nb[1] : nb[0];
  endfunction : lvl

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    int n;
    @(posedge core_clk_in);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    if (!w) rdq.push_back(exp);
    @(posedge core_clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      report_and_stop();
    end
  endtask : apb

  // waits for the cpu to take every noted vector, then watches for strays
  task automatic drain();
    int n;
    cpu_en <= 1'b1;
    n = 0;
    while (vq.size() != 0 && n < 400) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n >= 400) begin
      n_errors++;
      report_and_stop();
    end
    repeat (25) @(posedge core_clk_in);
    cpu_en <= 1'b0;
  endtask : drain

  always @(posedge core_clk_in) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, rdq.pop_front());
    if (ack && int_req_o === 1'b1) begin
      e = vq.size() != 0 ? vq.pop_front() : 6'h3F;
      chk({27'h0, vec}, {27'h0, e});
      chk({17'h0, vaddr}, {25'h0, e, 2'b00});
    end
  end

  initial begin
    repeat (90000) @(posedge core_clk_in);
    n_errors++;
    report_and_stop();
  end

  initial begin
    logic [31:0] r;
    logic [7:0]  pat, ena;
    logic [3:0]  nib;
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    apb(0, OFF_SYS_CTRL, 0, {25'h0, SYS_CTRL_RESET});
    apb(0, OFF_PRIO_A, 0, 33'h0);
    apb(0, OFF_PRIO_B, 0, 33'h0);
    apb(0, OFF_IRQ_ENABLE, 0, 33'h0);
    apb(0, 8'h40, 0, {1'b1, 32'h0});
    $display("test reset values done");
    apb(1, OFF_SENSE_CTRL, 32'hFF, 0);
    for (int k = 0; k < 5; k++) begin
      r = rnd();
      pat = r[7:0];
      ena = r[15:8];
      nib = r[19:16];
      delay <= r[23:20];
      apb(1, OFF_IRQ_ENABLE, {24'h0, ena}, 0);
      apb(1, OFF_PRIO_A, {24'h0, nib, 4'h0}, 0);
      irq_n <= ~pat;
      repeat (6) @(posedge core_clk_in);
      chk({32'h0, wake}, {32'h0, |(pat & ena & 8'h07)});
      apb(0, OFF_IRQ_STATUS, 0, {25'h0, pat});
      for (int l = 1; l >= 0; l--)
        for (int i = 0; i < 8; i++)
          if (pat[i] && ena[i] && lvl(nib, i) == l[0])
            vq.push_back(vec_t'(VEC_IRQ0 + i));
      drain();
      irq_n <= 8'hFF;
      apb(0, OFF_IRQ_STATUS, 0, {25'h0, pat & ~ena});
      apb(1, OFF_IRQ_STATUS, 0, 0);
      apb(0, OFF_IRQ_STATUS, 0, 33'h0);
    end
    $display("test irq arbitration done");
    mask_i <= 1'b1;
    mask_ui <= 1'b1;
    apb(1, OFF_IRQ_ENABLE, 32'h01, 0);
    irq_n <= 8'hFE;
    nmi_pin <= 1'b0;
    vq.push_back(VEC_NMI);
    drain();
    apb(1, OFF_SYS_CTRL, 32'h0C, 0);
    nmi_pin <= 1'b1;
    vq.push_back(VEC_NMI);
    drain();
    apb(1, OFF_SYS_CTRL, 32'h04, 0);
    apb(1, OFF_PRIO_A, 32'h80, 0);
    mask_ui <= 1'b0;
    vq.push_back(VEC_IRQ0);
    drain();
    irq_n <= 8'hFF;
    mask_i <= 1'b0;
    // level mode: a short low pulse on irq3 leaves its flag set until software clears it
    apb(1, OFF_SENSE_CTRL, 32'h0, 0);
    irq_n <= 8'hF7;
    repeat (4) @(posedge core_clk_in);
    irq_n <= 8'hFF;
    apb(0, OFF_IRQ_STATUS, 0, 33'h08);
    apb(1, OFF_IRQ_STATUS, 0, 0);
    apb(0, OFF_IRQ_STATUS, 0, 33'h0);
    $display("test nmi and masking done");
    apb(1, OFF_INT_EN_LO, 32'hFFFFFFFF, 0);
    apb(1, OFF_INT_EN_HI, 32'h3, 0);
    apb(1, OFF_DMA_SEL_LO, 32'h4, 0);
    int_req <= {1'b1, 30'h0, 3'b101};
    repeat (3) @(posedge core_clk_in);
    chk({int_req_o, dma_trig[31:0]}, {1'b1, 32'h4});
    chk({27'h0, vec}, 33'h14);
    apb(1, OFF_PRIO_B, 32'h02, 0);
    repeat (3) @(posedge core_clk_in);
    chk({27'h0, vec}, 33'h3C);
    int_req <= '0;
    $display("test internal sources done");
    report_and_stop();
  end
endmodule : tb_top
